//--- hw/sso_map.svh
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH
// register byte offsets
`define SSO_OFF_ASSIGN 8'h00
`define SSO_OFF_BRKDLY 8'h04
`define SSO_OFF_POSWIN 8'h08
`define SSO_OFF_ZERO   8'h0c
`define SSO_OFF_STATUS 8'h10
// pin assignment field positions
`define SSO_PIN_A_LSB  0
`define SSO_PIN_B_LSB  4
`define SSO_PIN_C_LSB  8
`define SSO_SEL_W      4
// reset values
`define SSO_BRKDLY_RST 16'h0064
`define SSO_POSWIN_RST 16'h0064
`define SSO_ZERO_RST   16'h0032
// speed figures in r/min, and the speed-reached divisor
`define SSO_ZERO_HYST  16'h0014
`define SSO_REACH_BASE 17'h00014
`define SSO_REACH_DIV  17'h00014
`define SSO_REACH_LOW  16'h0014
// power-on window in ms, and clock figures
`define SSO_PON_MIN_MS 2500
`define SSO_PON_MAX_MS 3500
`define SSO_CLK_PS     5000
`define SSO_MS_PS      1000000000
`endif

//--- hw/sso_pkg.sv
`default_nettype none
package sso_pkg;
  // status devices that a pin can carry
  typedef enum logic [3:0] {
    SSO_DEV_NONE, SSO_DEV_BRAKE, SSO_DEV_MALF, SSO_DEV_INPOS,
    SSO_DEV_DYNBRK, SSO_DEV_READY, SSO_DEV_SPDREACH,
    SSO_DEV_SPDLIM, SSO_DEV_ZERO
  } sso_dev_e;
  // control mode of the drive
  typedef enum logic [1:0] {
    SSO_MODE_POS, SSO_MODE_SPD, SSO_MODE_TRQ, SSO_MODE_CONT_TRQ
  } sso_mode_e;
  // drive state seen by the block
  typedef struct packed {
    logic              servo_on;
    logic              drive_ready;
    logic              alarm;
    logic              base_shut;
    sso_mode_e         mode;
    logic signed [15:0] droop;
    logic signed [15:0] speed;
    logic signed [15:0] set_speed;
    logic [15:0]       speed_limit;
  } sso_drive_s;
  // one bit per status device
  typedef struct packed {
    logic zero;
    logic spd_lim;
    logic spd_reach;
    logic ready;
    logic dynbrk;
    logic inpos;
    logic malf;
    logic brake;
  } sso_dev_s;
endpackage : sso_pkg
`default_nettype wire

//--- hw/sso_status_outputs.sv
// How it works
// - three pins, each device chosen by register
// - brake interlock off on servo-off or alarm
// - brake lock delay from delay register
// - malfunction off when base circuit shut
// - malfunction on 2.5-3.5 s after power-on
// - in-position while droop inside window
// - in-position unavailable outside position mode
// - ready once servo-on and drive ready
// - speed reached off while servo off
// - speed reached within set +-(5%+20)
// - set speed at most 20: always reached
// - speed reached only in speed mode
// - speed limiting when speed hits limit
// - speed limiting cleared while servo off
// - speed limiting only in torque modes
// - zero speed on at or below level
// - zero speed off at level plus 20
// - fixed 20 r/min zero-speed hysteresis
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`include "sso_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs #(
  parameter int MS_CYCLES = `SSO_MS_PS / `SSO_CLK_PS
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // drive state
  input  wire sso_pkg::sso_drive_s drive_i,
  // status pins and base hold
  output logic                    pin_a_o,
  output logic                    pin_b_o,
  output logic                    pin_c_o,
  output logic                    base_hold_o
);
  import sso_pkg::*;

  localparam logic [11:0] PON_MS =
    12'((`SSO_PON_MIN_MS + `SSO_PON_MAX_MS) / 2);

  logic [11:0]    assign_reg;
  logic [15:0]    brkdly_reg;
  logic [15:0]    poswin_reg;
  logic [15:0]    zero_lvl_reg;
  logic           ack_reg;
  logic [31:0]    rdata_reg;
  logic [17:0]    ms_cnt_reg;
  logic           ms_tick;
  logic [11:0]    pon_cnt_reg;
  logic           pon_done_reg;
  logic [15:0]    brk_cnt_reg;
  logic           brk_hold_reg;
  sso_dev_s       dev_reg;
  sso_dev_s       dev_next;
  logic [2:0]     pins_reg;
  logic [2:0]     pins_next;
  logic           brake_used;
  logic [15:0]    abs_speed;
  logic [15:0]    abs_set;
  logic [15:0]    abs_droop;
  logic [16:0]    reach_win;
  logic [16:0]    reach_diff;
  logic [15:0]    zero_off_lvl;
  logic           wb_req;
  logic [31:0]    status_word;

  // magnitude of a signed 16-bit value
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  // magnitude of a signed 17-bit value
  function automatic logic [16:0] mag17(input logic signed [16:0] v);
    mag17 = v[16] ? 17'(-v) : 17'(v);
  endfunction : mag17

  // device bit selected by a pin's assignment code
  function automatic logic pick(input sso_dev_s d,
                                input logic [3:0] sel);
    case (sel)
      SSO_DEV_BRAKE:    pick = d.brake;
      SSO_DEV_MALF:     pick = d.malf;
      SSO_DEV_INPOS:    pick = d.inpos;
      SSO_DEV_DYNBRK:   pick = d.dynbrk;
      SSO_DEV_READY:    pick = d.ready;
      SSO_DEV_SPDREACH: pick = d.spd_reach;
      SSO_DEV_SPDLIM:   pick = d.spd_lim;
      SSO_DEV_ZERO:     pick = d.zero;
      default:          pick = 1'b0;
    endcase
  endfunction : pick

  // bus request without wait state handling on the master side
  assign wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // register writes honour byte selects; unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_reg   <= {SSO_DEV_INPOS, SSO_DEV_MALF, SSO_DEV_BRAKE};
      brkdly_reg   <= `SSO_BRKDLY_RST;
      poswin_reg   <= `SSO_POSWIN_RST;
      zero_lvl_reg <= `SSO_ZERO_RST;
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        `SSO_OFF_ASSIGN: begin
          if (wb_sel_i[0]) assign_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) assign_reg[11:8] <= wb_dat_i[11:8];
        end
        `SSO_OFF_BRKDLY: begin
          if (wb_sel_i[0]) brkdly_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) brkdly_reg[15:8] <= wb_dat_i[15:8];
        end
        `SSO_OFF_POSWIN: begin
          if (wb_sel_i[0]) poswin_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) poswin_reg[15:8] <= wb_dat_i[15:8];
        end
        `SSO_OFF_ZERO: begin
          if (wb_sel_i[0]) zero_lvl_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) zero_lvl_reg[15:8] <= wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // live status word
  assign status_word = {19'h00000, brk_hold_reg, pon_done_reg,
                        pins_reg, dev_reg};

  // read data captured with the ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      case (wb_adr_i)
        `SSO_OFF_ASSIGN: rdata_reg <= {20'h00000, assign_reg};
        `SSO_OFF_BRKDLY: rdata_reg <= {16'h0000, brkdly_reg};
        `SSO_OFF_POSWIN: rdata_reg <= {16'h0000, poswin_reg};
        `SSO_OFF_ZERO:   rdata_reg <= {16'h0000, zero_lvl_reg};
        `SSO_OFF_STATUS: rdata_reg <= status_word;
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // millisecond enable from the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_reg <= 18'h00000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 18'h00001;
    end
  end
  assign ms_tick = (ms_cnt_reg == 18'(MS_CYCLES - 1));

  // power-on delay counted from reset release, mid-window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pon_cnt_reg  <= 12'h000;
      pon_done_reg <= 1'b0;
    end else if (ms_tick && !pon_done_reg) begin
      pon_cnt_reg  <= pon_cnt_reg + 12'h001;
      pon_done_reg <= (pon_cnt_reg == PON_MS - 12'h001);
    end
  end

  // delay only runs when a pin really carries the brake interlock
  assign brake_used = (assign_reg[`SSO_PIN_A_LSB +: `SSO_SEL_W]
                       == SSO_DEV_BRAKE) ||
                      (assign_reg[`SSO_PIN_B_LSB +: `SSO_SEL_W]
                       == SSO_DEV_BRAKE) ||
                      (assign_reg[`SSO_PIN_C_LSB +: `SSO_SEL_W]
                       == SSO_DEV_BRAKE);

  // base stays energised for the lock delay after the brake drops,
  // so the load is held while the mechanical lock engages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_cnt_reg  <= 16'h0000;
      brk_hold_reg <= 1'b0;
    end else if (dev_reg.brake) begin
      brk_cnt_reg  <= brkdly_reg;
      brk_hold_reg <= brake_used && (brkdly_reg != 16'h0000);
    end else if (brk_hold_reg && ms_tick) begin
      brk_cnt_reg  <= brk_cnt_reg - 16'h0001;
      brk_hold_reg <= (brk_cnt_reg != 16'h0001);
    end
  end
  assign base_hold_o = brk_hold_reg;

  // magnitudes and the speed-reached window
  assign abs_speed    = mag16(drive_i.speed);
  assign abs_set      = mag16(drive_i.set_speed);
  assign abs_droop    = mag16(drive_i.droop);
  assign reach_win    = {1'b0, abs_set} / `SSO_REACH_DIV
                        + `SSO_REACH_BASE;
  assign reach_diff   = mag17(17'(drive_i.speed) -
                              17'(drive_i.set_speed));
  assign zero_off_lvl = zero_lvl_reg + `SSO_ZERO_HYST;

  // next value of every status device
  always_comb begin
    dev_next = '0;
    dev_next.brake  = drive_i.servo_on && !drive_i.alarm;
    dev_next.dynbrk = drive_i.servo_on && !drive_i.alarm;
    dev_next.malf   = pon_done_reg && !drive_i.alarm &&
                      !drive_i.base_shut;
    dev_next.inpos  = (drive_i.mode == SSO_MODE_POS) &&
                      (abs_droop <= poswin_reg);
    dev_next.ready  = drive_i.servo_on && drive_i.drive_ready &&
                      !drive_i.alarm;
    if (drive_i.servo_on && drive_i.mode == SSO_MODE_SPD) begin
      dev_next.spd_reach = (abs_set <= `SSO_REACH_LOW) ||
                           (reach_diff <= reach_win);
    end
    if (drive_i.servo_on && (drive_i.mode == SSO_MODE_TRQ ||
        drive_i.mode == SSO_MODE_CONT_TRQ)) begin
      dev_next.spd_lim = abs_speed >= drive_i.speed_limit;
    end
    if (dev_reg.zero) begin
      dev_next.zero = abs_speed < zero_off_lvl;
    end else begin
      dev_next.zero = abs_speed <= zero_lvl_reg;
    end
  end

  // routing of the devices onto the three pins
  for (genvar p = 0; p < 3; p++) begin : g_pin
    assign pins_next[p] =
      pick(dev_next, assign_reg[p*`SSO_SEL_W +: `SSO_SEL_W]);
  end

  // all devices and pins change together on the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_reg  <= '0;
      pins_reg <= 3'h0;
    end else begin
      dev_reg  <= dev_next;
      pins_reg <= pins_next;
    end
  end
  assign pin_a_o = pins_reg[0];
  assign pin_b_o = pins_reg[1];
  assign pin_c_o = pins_reg[2];

  // checks on the devices and the bus
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_brake_off_cause: assert property (
    (!drive_i.servo_on || drive_i.alarm) |=> !dev_reg.brake)
    else $error("brake interlock on during servo-off or alarm");

  a_malf_shut_off: assert property (
    drive_i.base_shut |=> !dev_reg.malf)
    else $error("malfunction output on with base circuit shut");

  a_malf_pon_wait: assert property (
    !pon_done_reg |=> !dev_reg.malf)
    else $error("malfunction output on before power-on delay");

  a_inpos_mode_gate: assert property (
    (drive_i.mode != SSO_MODE_POS) |=> !dev_reg.inpos)
    else $error("in-position on outside position mode");

  // speed reached lives only in speed mode with the servo on
  a_reach_servo_off: assert property (
    !drive_i.servo_on |=> !dev_reg.spd_reach)
    else $error("speed reached on while servo off");

  a_reach_low_set: assert property (
    (!rst_i && drive_i.servo_on && drive_i.mode == SSO_MODE_SPD &&
     abs_set <= `SSO_REACH_LOW) |=> dev_reg.spd_reach)
    else $error("speed reached off with low set speed");

  a_reach_mode_gate: assert property (
    (drive_i.mode != SSO_MODE_SPD) |=> !dev_reg.spd_reach)
    else $error("speed reached on outside speed mode");

  a_lim_mode_gate: assert property (
    (drive_i.mode == SSO_MODE_POS || drive_i.mode == SSO_MODE_SPD ||
     !drive_i.servo_on) |=> !dev_reg.spd_lim)
    else $error("speed limiting on in wrong mode or servo off");

  a_lim_at_limit: assert property (
    (!rst_i && drive_i.servo_on &&
     (drive_i.mode == SSO_MODE_TRQ || drive_i.mode == SSO_MODE_CONT_TRQ) &&
     abs_speed >= drive_i.speed_limit) |=> dev_reg.spd_lim)
    else $error("speed limiting off at the speed limit");

  // zero band: on at the level, off only at level plus the hysteresis
  a_zero_hyst_hold: assert property (
    (dev_reg.zero && abs_speed < zero_off_lvl) |=> dev_reg.zero)
    else $error("zero speed released below off level");

  a_zero_release: assert property (
    (abs_speed >= zero_off_lvl && zero_off_lvl > zero_lvl_reg)
    |=> !dev_reg.zero)
    else $error("zero speed held at or above off level");

  a_zero_on_level: assert property (
    (!rst_i && abs_speed <= zero_lvl_reg) |=> dev_reg.zero)
    else $error("zero speed off at or below on level");

  // ready and in-position follow their causes one cycle later
  a_ready_on_cause: assert property (
    (!rst_i && drive_i.servo_on && drive_i.drive_ready &&
     !drive_i.alarm) |=> dev_reg.ready)
    else $error("ready off although servo on and drive ready");

  a_ready_off_cause: assert property (
    (!drive_i.servo_on || drive_i.alarm) |=> !dev_reg.ready)
    else $error("ready on during servo-off or alarm");

  a_inpos_window: assert property (
    (!rst_i && drive_i.mode == SSO_MODE_POS &&
     abs_droop <= poswin_reg) |=> dev_reg.inpos)
    else $error("in-position off with droop inside window");

  // malfunction must come on once the power-on wait is over
  a_malf_on_clear: assert property (
    (!rst_i && pon_done_reg && !drive_i.alarm &&
     !drive_i.base_shut) |=> dev_reg.malf)
    else $error("malfunction output off after power-on delay");

  // base hold is armed while the brake is on, unless no delay is set or no pin carries the brake
  a_hold_armed: assert property (
    (!rst_i && dev_reg.brake && brake_used &&
     brkdly_reg != 16'h0000) |=> brk_hold_reg)
    else $error("base hold not armed while brake interlock on");

  a_hold_zero_delay: assert property (
    (dev_reg.brake && brkdly_reg == 16'h0000) |=> !brk_hold_reg)
    else $error("base hold armed with zero lock delay");

  a_bus_ack_once: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");

  c_brake_release: cover property ($fell(dev_reg.brake));
  c_base_hold_end: cover property ($fell(brk_hold_reg));
  c_zero_cycle: cover property ($rose(dev_reg.zero) ##[1:20]
                                $fell(dev_reg.zero));
  c_reach_hit: cover property ($rose(dev_reg.spd_reach));
  c_pon_done: cover property ($rose(pon_done_reg));
endmodule : sso_status_outputs
`default_nettype wire

//--- testbench/sso_brake_model.sv
`timescale 1ns/1ps
`default_nettype none
module sso_brake_model (
  // clock
  input  wire logic clk_i,
  // pins seen by the brake circuit
  input  wire logic brake_pin_i,
  input  wire logic hold_i,
  // mechanical brake state
  output logic      lock_o
);
  // lock only once interlock is off and hold time is over, so the
  // motor never drags against a closing brake
  always_ff @(posedge clk_i) begin
    lock_o <= !brake_pin_i && !hold_i;
  end
endmodule : sso_brake_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sso_pkg::*;
  localparam sso_mode_e PO = SSO_MODE_POS, SP = SSO_MODE_SPD;
  localparam sso_mode_e TQ = SSO_MODE_TRQ, CT = SSO_MODE_CONT_TRQ;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, q;
  logic        wb_ack, pin_a, pin_b, pin_c, hold, lock;
  sso_drive_s  drv = '0;
  logic [11:0] asg = 12'h321;
  int          fails = 0, total_checks = 0, cyc_cnt = 0, since_rst = 0;
  // short ms tick keeps the power-on wait near 30000 cycles
  sso_status_outputs #(.MS_CYCLES(10)) sso_status_outputs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .drive_i(drv), .pin_a_o(pin_a), .pin_b_o(pin_b), .pin_c_o(pin_c),
    .base_hold_o(hold));
  sso_brake_model sso_brake_model_inst (
    .clk_i(clk_i), .brake_pin_i(pin_a), .hold_i(hold), .lock_o(lock));
  always #2.5 clk_i = ~clk_i;
  // cycle count, time since reset release and hang guard
  always @(posedge clk_i) begin
    cyc_cnt++;
    since_rst = rst_i ? 0 : since_rst + 1;
    if (cyc_cnt > 60000) begin
      fails++;
      summarize();
    end
  end
  task summarize;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled high
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    // no wait limit here: only the hang guard may end a wait
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  function automatic logic pexp(input logic [3:0] c, input logic [7:0] e);
    return (c >= 4'h1 && c <= 4'h8) ? e[c-4'h1] : 1'b0;
  endfunction : pexp
  function automatic sso_drive_s mk(input logic so, rd, al, bs,
    input sso_mode_e m, input int dr, sp, st, lm);
    return {so, rd, al, bs, m, 16'(dr), 16'(sp), 16'(st), 16'(lm)};
  endfunction : mk
  // drive a state, then compare device bits and all three pins
  task apply(input sso_drive_s d, input logic [7:0] e);
    @(posedge clk_i);
    drv <= d;
    wb(8'h10, 1'b0, 32'h0);
    check({24'h0, q[7:0]}, {24'h0, e});
    check({29'h0, pin_c, pin_b, pin_a}, {29'h0, pexp(asg[11:8], e),
      pexp(asg[7:4], e), pexp(asg[3:0], e)});
  endtask : apply
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  logic [31:0] rv[5] = '{32'h321, 32'h64, 32'h64, 32'h32, 32'h0};
  int          zs[10] = '{51, 50, 69, 70, -50, -69, -70, 100, 119, 120};
  logic [7:0]  ze[10] = '{8'h1b, 8'h9b, 8'h9b, 8'h1b, 8'h9b, 8'h9b,
                          8'h1b, 8'h9b, 8'h9b, 8'h1b};
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(ra[i], 1'b0, 32'h0);
      check(q, rv[i]);
    end
    while (since_rst < 24000) @(posedge clk_i);
    wb(8'h10, 1'b0, 32'h0);
    check({30'h0, q[11], q[1]}, 32'h0);
    while (since_rst < 35100) @(posedge clk_i);
    wb(8'h10, 1'b0, 32'h0);
    check({30'h0, q[11], q[1]}, 32'h3);
    apply(mk(1, 1, 0, 0, PO, 100, 0, 0, 1000), 8'h9f);
    apply(mk(1, 1, 0, 0, PO, -101, 0, 0, 1000), 8'h9b);
    apply(mk(1, 1, 1, 0, PO, 0, 0, 0, 1000), 8'h84);
    apply(mk(1, 1, 0, 1, PO, 0, 0, 0, 1000), 8'h9d);
    apply(mk(1, 1, 0, 0, SP, 0, 1070, 1000, 1000), 8'h3b);
    apply(mk(1, 1, 0, 0, SP, 0, 1071, 1000, 1000), 8'h1b);
    apply(mk(1, 1, 0, 0, SP, 0, -930, -1000, 1000), 8'h3b);
    apply(mk(1, 1, 0, 0, SP, 0, 500, 20, 1000), 8'h3b);
    apply(mk(0, 1, 0, 0, SP, 0, 500, 20, 1000), 8'h02);
    apply(mk(1, 1, 0, 0, TQ, 0, 1000, 0, 1000), 8'h5b);
    apply(mk(1, 1, 0, 0, TQ, 0, 999, 0, 1000), 8'h1b);
    apply(mk(1, 1, 0, 0, CT, 0, 1000, 0, 1000), 8'h5b);
    apply(mk(0, 1, 0, 0, TQ, 0, 1000, 0, 1000), 8'h02);
    apply(mk(1, 1, 0, 0, PO, 0, 1000, 0, 100), 8'h1f);
    // walk through the zero-speed band, then with a raised level
    for (int i = 0; i < 10; i++) begin
      if (i == 7) wb(8'h0c, 1'b1, 32'h64);
      apply(mk(1, 1, 0, 0, TQ, 0, zs[i], 0, 32767), ze[i]);
    end
    // selector codes 0 to 9 on all three pins
    for (int c = 0; c < 10; c++) begin
      asg = {3{4'(c)}};
      wb(8'h00, 1'b1, {20'h0, asg});
      apply(mk(1, 1, 0, 0, PO, 0, 0, 0, 1000), 8'h9f);
    end
    asg = 12'h321;
    wb(8'h00, 1'b1, {20'h0, asg});
    wb(8'h04, 1'b1, 32'h3);
    apply(mk(0, 1, 0, 0, PO, 0, 0, 0, 1000), 8'h86);
    check({30'h0, hold, lock}, 32'h2);
    repeat (45) @(posedge clk_i);
    check({30'h0, hold, lock}, 32'h1);
    wb(8'h04, 1'b1, 32'h0);
    apply(mk(1, 1, 0, 0, PO, 0, 0, 0, 1000), 8'h9f);
    apply(mk(0, 1, 0, 0, PO, 0, 0, 0, 1000), 8'h86);
    check({31'h0, hold}, 32'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
